// >>> switch_table_access_pkg.sv
// constants for the switch table access command and status block
// assumes word registers on a plain strobe port, byte address = 4 * index
package switch_table_access_pkg;
  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam logic [15:0] IDX_VLAN_COMMAND   = 16'h1808;
  localparam logic [15:0] IDX_VLAN_DATA      = 16'h1809;
  localparam logic [15:0] IDX_VLAN_STATUS    = 16'h1810;
  localparam logic [15:0] IDX_CP_COMMAND     = 16'h1811;
  localparam logic [15:0] IDX_CP_WRITE_DATA  = 16'h1812;
  localparam logic [15:0] IDX_CP_READ_DATA   = 16'h1813;
  localparam logic [15:0] IDX_CP_STATUS      = 16'h1814;
  localparam logic [15:0] ADDR_VLAN_COMMAND  = 16'(IDX_VLAN_COMMAND * 4);
  localparam logic [15:0] ADDR_VLAN_DATA     = 16'(IDX_VLAN_DATA * 4);
  localparam logic [15:0] ADDR_VLAN_STATUS   = 16'(IDX_VLAN_STATUS * 4);
  localparam logic [15:0] ADDR_CP_COMMAND    = 16'(IDX_CP_COMMAND * 4);
  localparam logic [15:0] ADDR_CP_WRITE_DATA = 16'(IDX_CP_WRITE_DATA * 4);
  localparam logic [15:0] ADDR_CP_READ_DATA  = 16'(IDX_CP_READ_DATA * 4);
  localparam logic [15:0] ADDR_CP_STATUS     = 16'(IDX_CP_STATUS * 4);
  // ---------------------------------------------------------------
  // field positions, widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PENDING_BIT   = 0;
  localparam int unsigned READ_NOT_WRITE_BIT = 7;
  localparam int unsigned CP_INDEX_W    = 6;
  localparam int unsigned CP_PRIO_W     = 3;
  localparam int unsigned VLAN_ID_W     = 12;
  localparam int unsigned VLAN_INDEX_W  = 4;
  localparam logic [11:0] VLAN_ID_NULL  = 12'h000;
  localparam logic [11:0] VLAN_ID_RSVD  = 12'h3FF;
  localparam logic        READ_NOT_WRITE_RESET = 1'b0;
  localparam logic [5:0]  CP_INDEX_RESET = 6'h00;
  localparam logic [2:0]  CP_PRIO_RESET = 3'h0;
  localparam logic [11:0] VLAN_ID_RESET = 12'h000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned ACCESS_CYCLES = 2;
endpackage

// >>> switch_table_access_cmd.sv
// indirect command and status access to the vlan and codepoint tables
// assumes one 40 MHz clock, synchronous inputs and a host that polls
//
// Behaviour
// RQ1 - vlan entry data keeps a 12-bit vlan identifier in bits 11:0
// RQ2 - software writes identifier zero only to disable an entry
// RQ3 - software never programs the reserved identifier 3FFh
// RQ4 - vlan status bit 0 is high while a vlan command runs, self-clears
// RQ5 - every codepoint command write launches the access it describes
// RQ6 - codepoint table maps received class field to receive priority
// RQ7 - read keeps pending set until read data is valid
// RQ8 - software stages write data before issuing a write command
// RQ9 - command bit 7 is read(1) or write(0), resets to zero
// RQ10 - index in bits 5:0 picks one of 64 entries, 31:8 and 6 read zero
// RQ11 - entry holds 3-bit priority in bits 2:0 of write and read data
// RQ12 - codepoint table is not cleared by reset; software fills it
// RQ13 - codepoint status bit 0 is pending, set per command, self-clears
// RQ14 - software issues no command or data change while pending
`timescale 1ns/100ps
module switch_table_access_cmd #(
  parameter int unsigned ACCESS_CYCLES = switch_table_access_pkg::ACCESS_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic [15:0] i_address,
  input  wire logic [31:0] i_write_data,
  input  wire logic        i_write,
  input  wire logic        i_read,
  input  wire logic [5:0]  i_class_code,
  output logic      [31:0] o_read_data,
  output logic      [2:0]  o_rx_priority
);
  // ---------------------------------------------------------------
  // elaboration checks and local types
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(ACCESS_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ACCESS_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  generate
    if (ACCESS_CYCLES < 1) begin : g_bad_cycles
      $error("ACCESS_CYCLES must be at least one");
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic wr_vlan_cmd, wr_vlan_data, wr_cp_cmd, wr_cp_data;
  assign wr_vlan_cmd  = i_write &&
                        i_address == switch_table_access_pkg::ADDR_VLAN_COMMAND;
  assign wr_vlan_data = i_write &&
                        i_address == switch_table_access_pkg::ADDR_VLAN_DATA;
  assign wr_cp_cmd    = i_write &&
                        i_address == switch_table_access_pkg::ADDR_CP_COMMAND;
  assign wr_cp_data   = i_write &&
      i_address == switch_table_access_pkg::ADDR_CP_WRITE_DATA;

  // ---------------------------------------------------------------
  // codepoint command, staging and pending counter
  // ---------------------------------------------------------------
  logic             cp_read_not_write_r;
  logic [5:0]       cp_index_r;
  logic [2:0]       cp_wdata_r;
  logic [2:0]       cp_rdata_r;
  logic [CNT_W-1:0] cp_cnt_r;
  logic             cp_pend;
  logic             cp_done;
  logic [2:0]       cp_mem [64];
  logic [2:0]       lookup_now;

  assign cp_pend    = cp_cnt_r != CNT_ZERO;
  assign cp_done    = cp_cnt_r == CNT_ONE && !wr_cp_cmd;
  assign lookup_now = cp_mem[i_class_code];

  // command fields; a new command restarts the access rather than queueing
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin                                    // RQ9
      cp_read_not_write_r <= switch_table_access_pkg::READ_NOT_WRITE_RESET;
      cp_index_r          <= switch_table_access_pkg::CP_INDEX_RESET;
    end else if (wr_cp_cmd) begin
      cp_read_not_write_r <=
          i_write_data[switch_table_access_pkg::READ_NOT_WRITE_BIT];  // RQ9
      cp_index_r          <= i_write_data[5:0];              // RQ10
    end
  end

  // staged priority for the next table write
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cp_wdata_r <= switch_table_access_pkg::CP_PRIO_RESET;
    end else if (wr_cp_data) begin
      cp_wdata_r <= i_write_data[2:0];                       // RQ11
    end
  end

  // pending: loaded by a command write, which wins over the countdown
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cp_cnt_r <= CNT_ZERO;
    end else if (wr_cp_cmd) begin
      cp_cnt_r <= CNT_LOAD;                                  // RQ5 RQ13
    end else if (cp_pend) begin
      cp_cnt_r <= cp_cnt_r - CNT_ONE;                        // RQ13
    end
  end

  // read result lands in the same edge that pending drops
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cp_rdata_r <= switch_table_access_pkg::CP_PRIO_RESET;
    end else if (cp_done && cp_read_not_write_r) begin
      cp_rdata_r <= cp_mem[cp_index_r];                      // RQ7
    end
  end

  // table storage has no reset: contents are undefined until written
  always_ff @(posedge i_clock) begin
    if (cp_done && !cp_read_not_write_r) begin
      cp_mem[cp_index_r] <= cp_wdata_r;                      // RQ12
    end
  end

  // receive path lookup, one cycle of latency
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_priority <= switch_table_access_pkg::CP_PRIO_RESET;
    end else begin
      o_rx_priority <= lookup_now;                           // RQ6
    end
  end

  // ---------------------------------------------------------------
  // vlan table access
  // ---------------------------------------------------------------
  logic             vl_read_not_write_r;
  logic [3:0]       vl_index_r;
  logic [11:0]      vl_wdata_r;
  logic [11:0]      vl_rdata_r;
  logic [CNT_W-1:0] vl_cnt_r;
  logic             vl_pend;
  logic             vl_done;
  logic [11:0]      vl_mem [16];

  assign vl_pend = vl_cnt_r != CNT_ZERO;
  assign vl_done = vl_cnt_r == CNT_ONE && !wr_vlan_cmd;

  // vlan command fields
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vl_read_not_write_r <= switch_table_access_pkg::READ_NOT_WRITE_RESET;
      vl_index_r          <= 4'h0;
    end else if (wr_vlan_cmd) begin
      vl_read_not_write_r <=
          i_write_data[switch_table_access_pkg::READ_NOT_WRITE_BIT];
      vl_index_r          <= i_write_data[3:0];
    end
  end

  // staged identifier; zero and 3FFh are stored as given, software's care
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vl_wdata_r <= switch_table_access_pkg::VLAN_ID_RESET;
    end else if (wr_vlan_data) begin
      vl_wdata_r <= i_write_data[11:0];                      // RQ1
    end
  end

  // vlan pending countdown
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vl_cnt_r <= CNT_ZERO;
    end else if (wr_vlan_cmd) begin
      vl_cnt_r <= CNT_LOAD;                                  // RQ4
    end else if (vl_pend) begin
      vl_cnt_r <= vl_cnt_r - CNT_ONE;                        // RQ4
    end
  end

  // vlan read result and entry storage
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vl_rdata_r <= switch_table_access_pkg::VLAN_ID_RESET;
    end else if (vl_done && vl_read_not_write_r) begin
      vl_rdata_r <= vl_mem[vl_index_r];                      // RQ1
    end
  end

  always_ff @(posedge i_clock) begin
    if (vl_done && !vl_read_not_write_r) begin
      vl_mem[vl_index_r] <= vl_wdata_r;                      // RQ1
    end
  end

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ---------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (i_address)
      switch_table_access_pkg::ADDR_VLAN_COMMAND:
        rd_nxt = {24'h00_0000, vl_read_not_write_r, 3'h0, vl_index_r};
      switch_table_access_pkg::ADDR_VLAN_DATA:
        rd_nxt = {20'h0_0000, vl_rdata_r};                   // RQ1
      switch_table_access_pkg::ADDR_VLAN_STATUS:
        rd_nxt = {31'h0000_0000, vl_pend};                   // RQ4
      switch_table_access_pkg::ADDR_CP_COMMAND:              // RQ10
        rd_nxt = {24'h00_0000, cp_read_not_write_r, 1'b0, cp_index_r};
      switch_table_access_pkg::ADDR_CP_WRITE_DATA:
        rd_nxt = {29'h0000_0000, cp_wdata_r};                // RQ11
      switch_table_access_pkg::ADDR_CP_READ_DATA:
        rd_nxt = {29'h0000_0000, cp_rdata_r};                // RQ11
      switch_table_access_pkg::ADDR_CP_STATUS:
        rd_nxt = {31'h0000_0000, cp_pend};                   // RQ13
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_read_data <= 32'h0000_0000;
    end else if (i_read) begin
      o_read_data <= rd_nxt;
    end else begin
      o_read_data <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // entries written since reset; the lookup check skips undefined entries
  logic [63:0] cp_filled_r;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cp_filled_r <= 64'h0000_0000_0000_0000;
    end else if (cp_done && !cp_read_not_write_r) begin
      cp_filled_r[cp_index_r] <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  cp_launch_a: assert property (wr_cp_cmd |=> cp_pend) // RQ5
    else $error("codepoint command did not raise pending");
  vl_launch_a: assert property (wr_vlan_cmd |=> vl_pend) // RQ4
    else $error("vlan command did not raise pending");
  cp_pend_len_a: assert property ( // RQ13
      $fell(cp_pend) |-> !$past(wr_cp_cmd) && $past(cp_cnt_r) == CNT_ONE)
    else $error("codepoint pending ended at the wrong time");
  cp_read_ready_a: assert property ( // RQ7
      cp_done && cp_read_not_write_r |=>
      !cp_pend && cp_rdata_r == $past(cp_mem[cp_index_r]))
    else $error("read data not valid when pending cleared");
  cp_write_store_a: assert property ( // RQ11
      cp_done && !cp_read_not_write_r |=>
      cp_mem[$past(cp_index_r)] == $past(cp_wdata_r))
    else $error("table write did not store staged priority");
  cmd_rsvd_zero_a: assert property ( // RQ10
      i_read && i_address == switch_table_access_pkg::ADDR_CP_COMMAND |=>
      o_read_data[31:8] == 24'h00_0000 && !o_read_data[6])
    else $error("reserved command bits not zero");
  cmd_direction_a: assert property ( // RQ9
      wr_cp_cmd |=> cp_read_not_write_r == $past(i_write_data[7]))
    else $error("direction bit not captured");
  status_read_a: assert property ( // RQ13
      i_read && i_address == switch_table_access_pkg::ADDR_CP_STATUS |=>
      o_read_data == {31'h0000_0000, $past(cp_pend)})
    else $error("status read disagrees with pending");
  vlan_id_width_a: assert property ( // RQ1
      i_read && i_address == switch_table_access_pkg::ADDR_VLAN_DATA |=>
      o_read_data[31:12] == 20'h0_0000)
    else $error("vlan data upper bits not zero");
  lookup_map_a: assert property ( // RQ6
      cp_filled_r[i_class_code] |=> o_rx_priority == $past(lookup_now))
    else $error("receive priority lookup mismatch");
  read_one_cycle_a: assert property (!i_read |=> o_read_data == 32'h0)
    else $error("read data held beyond its cycle");

  cp_write_c: cover property (wr_cp_data ##[1:4] wr_cp_cmd ##[1:4] cp_done);
  cp_read_c:  cover property (cp_done && cp_read_not_write_r ##1 i_read &&
                  i_address == switch_table_access_pkg::ADDR_CP_READ_DATA);
  vl_read_c:  cover property (vl_done && vl_read_not_write_r);
  restart_c:  cover property (cp_pend && wr_cp_cmd);
endmodule

// >>> tb_top.sv
// self-checking bench for the switch table access command block
// assumes the design's own assertions run beside it; the bench is the host
`timescale 1ns/100ps
module tb_top;
  // ---------------------------------------------------------------
  // addresses and signals
  // ---------------------------------------------------------------
  // a longer access than the default keeps the pending window observable
  localparam int unsigned ACC  = 4;
  localparam logic [15:0] A_CMD = switch_table_access_pkg::ADDR_CP_COMMAND;
  localparam logic [15:0] A_WD  = switch_table_access_pkg::ADDR_CP_WRITE_DATA;
  localparam logic [15:0] A_RD  = switch_table_access_pkg::ADDR_CP_READ_DATA;
  localparam logic [15:0] A_ST  = switch_table_access_pkg::ADDR_CP_STATUS;
  localparam logic [15:0] V_CMD = switch_table_access_pkg::ADDR_VLAN_COMMAND;
  localparam logic [15:0] V_DAT = switch_table_access_pkg::ADDR_VLAN_DATA;
  localparam logic [15:0] V_ST  = switch_table_access_pkg::ADDR_VLAN_STATUS;
  logic        i_clock;
  logic        i_reset_n;
  logic [15:0] i_address;
  logic [31:0] i_write_data;
  logic        i_write;
  logic        i_read;
  logic [5:0]  i_class_code;
  logic [31:0] o_read_data;
  logic [2:0]  o_rx_priority;
  int          miscompares;
  int          checks;
  logic [2:0]  prio_tbl [64];
  logic [11:0] vlan_id_tbl [4];
  logic [31:0] rdv;
  logic [5:0]  idx;

  switch_table_access_cmd #(.ACCESS_CYCLES(ACC)) switch_table_access_cmd_inst (
    .i_clock      (i_clock),
    .i_reset_n    (i_reset_n),
    .i_address    (i_address),
    .i_write_data (i_write_data),
    .i_write      (i_write),
    .i_read       (i_read),
    .i_class_code (i_class_code),
    .o_read_data  (o_read_data),
    .o_rx_priority(o_rx_priority)
  );

  // ---------------------------------------------------------------
  // host tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle strobes; release happens at the next edge, never earlier
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_address    <= a;
    i_write_data <= d;
    i_write      <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_read    <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 d = o_read_data;
  endtask

  task automatic wait_idle(input logic [15:0] a);
    int n;
    for (n = 0; n < 20; n++) begin
      rd(a, rdv);
      if (rdv[0] === 1'b0) break;
    end
    if (n == 20) begin
      miscompares++;
      $display("ERROR pending expected 0 seen 1");
      stop_test();
    end
  endtask

  // launch a command, see pending rise at once, then poll it down
  task automatic op(input logic [15:0] ca, input logic [15:0] sa,
                    input logic [31:0] c);
    wr(ca, c);
    rd(sa, rdv);
    chk("pending", rdv, 32'h00000001);
    wait_idle(sa);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    miscompares++;
    stop_test();
  end

  initial begin
    i_reset_n    = 1'b0;
    i_address    = 16'h0000;
    i_write_data = 32'h00000000;
    i_write      = 1'b0;
    i_read       = 1'b0;
    i_class_code = 6'h00;
    miscompares  = 0;
    checks       = 0;
    void'($urandom(32'h9b8718f6));
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    // reset values and an unmapped address
    rd(A_CMD, rdv);
    chk("cmd reset", rdv, 32'h00000000);
    rd(A_ST, rdv);
    chk("cp status reset", rdv, 32'h00000000);
    rd(V_ST, rdv);
    chk("vlan status reset", rdv, 32'h00000000);
    rd(16'h0004, rdv);
    chk("unmapped", rdv, 32'h00000000);
    $display("test reset values done");
    // fill every entry, staging data first with junk in the upper bits
    for (int i = 0; i < 64; i++) begin
      prio_tbl[i] = 3'($urandom);
      wr(A_WD, {29'($urandom), prio_tbl[i]});
      op(A_CMD, A_ST, {24'h000000, 2'b00, 6'(i)});
    end
    $display("test table fill done");
    // read back, boundary indices first, then random ones
    for (int i = 0; i < 24; i++) begin
      idx = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
      op(A_CMD, A_ST, {24'h000000, 2'b10, idx});
      rd(A_RD, rdv);
      chk("cp read data", rdv, {29'h0, prio_tbl[idx]});
    end
    // all ones: reserved bits vanish, read of entry 63 is launched
    wr(A_CMD, 32'hFFFFFFFF);
    rd(A_CMD, rdv);
    chk("cmd fields", rdv, 32'h000000BF);
    wait_idle(A_ST);
    rd(A_RD, rdv);
    chk("cp read 63", rdv, {29'h0, prio_tbl[63]});
    $display("test table read done");
    // lookup path follows the class code one cycle later
    for (int i = 0; i < 40; i++) begin
      idx = 6'($urandom);
      @(posedge i_clock);
      i_class_code <= idx;
      @(posedge i_clock);
      #1 chk("rx priority", {29'h0, o_rx_priority},
             {29'h0, prio_tbl[idx]});
    end
    $display("test lookup done");
    // vlan entries: never the null or reserved identifier
    for (int i = 0; i < 4; i++) begin
      vlan_id_tbl[i] = 12'($urandom_range(4095, 1));
      if (vlan_id_tbl[i] == 12'h3FF) begin
        vlan_id_tbl[i] = 12'h001;
      end
      wr(V_DAT, {20'hFFFFF, vlan_id_tbl[i]});
      op(V_CMD, V_ST, {24'h000000, 4'h0, 4'(i)});
    end
    for (int i = 0; i < 4; i++) begin
      op(V_CMD, V_ST, {24'h000000, 4'h8, 4'(i)});
      rd(V_DAT, rdv);
      chk("vlan identifier", rdv, {20'h0, vlan_id_tbl[i]});
    end
    $display("test vlan done");
    stop_test();
  end
endmodule
